// ---- pkg/rcec_pkg.sv ----
// constants for the reset and clock-enable control block
// assumes a 100 MHz core clock and a slow low-frequency clock enable tick
package rcec_pkg;
	localparam int CLK_HZ          = 100_000_000;
	localparam int LF_HZ           = 32_000;
	// filtered pin reset window, microseconds
	localparam int PIN_DLY_MIN_US  = 1500;
	localparam int PIN_DLY_MAX_US  = 4000;
	localparam int PIN_HOLD_REC_US = 5000;
	// target between the bounds, in low-frequency ticks
	localparam int PIN_DLY_LF      = (LF_HZ / 1000) * 2;
	// core cycles per low-frequency tick
	localparam int LF_DIV          = CLK_HZ / LF_HZ;
	localparam int LF_DIV_W        = 16;
	localparam int CNT_W           = 8;
	// release stretch in core cycles after all sources drop
	localparam int REL_CYC         = 4;
	// crystal divider select: reset value is the slowest setting
	localparam logic [1:0] XSEL_RST = 2'h3;
	localparam int PIO_W           = 12;
	localparam int AIO_W           = 3;
endpackage

// ---- hdl/rcec_sync3.sv ----
// three-stage input synchroniser with agreement filter
// assumes input comes from outside the clk domain
`timescale 1ns/1ns
`default_nettype none
module rcec_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic din,
	output var  logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic o;
	} rcec_sy_t;
	rcec_sy_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// change counts once stages two and three agree
		if (st_q.s2 == st_q.s3) begin
			st_d.o = st_q.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= {4{RST_VAL}};
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.o;
endmodule
`default_nettype wire

// ---- hdl/rcec_top.sv ----
// reset gathering, pad reset states and clock-enable OR output
// assumes pins pass through rcec_sync3; pad drivers outside apply pulls
`timescale 1ns/1ns
`default_nettype none
module rcec_top #(
	parameter int PIN_DLY = rcec_pkg::PIN_DLY_LF,
	parameter int LF_DIVIDE = rcec_pkg::LF_DIV
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic                       reset_high_pin,
	input  wire logic                       reset_low_pin,
	input  wire logic                       power_on_det,
	input  wire logic                       uart_break,
	input  wire logic                       watchdog_expire,
	input  wire logic                       fw_fault_reset,
	input  wire logic                       warm_reset_req,
	input  wire logic                       crystal_clk_present,
	input  wire logic [1:0]                 xtal_sel_cfg,
	input  wire logic                       xtal_sel_wr,
	input  wire logic                       host_clk_enable,
	input  wire logic                       own_osc_enable,
	input  wire logic                       or_func_cfg,
	input  wire logic                       osc_pin_cfg_wr,
	input  wire logic                       deep_sleep,
	input  wire logic                       regulator_enable_pin,
	output var  logic                       int_reset,
	output var  logic                       cold_reset,
	output var  logic                       retain_state,
	output var  logic [1:0]                 xtal_sel,
	output var  logic                       osc_free_run,
	output var  logic                       osc_en_out,
	output var  logic                       osc_en_oe,
	output var  logic [rcec_pkg::PIO_W-1:0] programmable_io_line_oe,
	output var  logic [rcec_pkg::PIO_W-1:0] programmable_io_line_pd,
	output var  logic                       uart_tx_oe,
	output var  logic                       uart_rts_oe,
	output var  logic                       uart_pu,
	output var  logic                       spi_miso_oe,
	output var  logic                       spi_miso_pd,
	output var  logic                       peripheral_chip_select_pin_pu,
	output var  logic                       reset_low_pin_pu,
	output var  logic                       other_inputs_pd,
	output var  logic                       test_en_strong_pd,
	output var  logic [rcec_pkg::AIO_W-1:0] analogue_interface_pins_out,
	output var  logic [rcec_pkg::AIO_W-1:0] analogue_interface_pins_oe,
	output var  logic                       regulator_low_power,
	output var  logic                       regulator_on,
	output var  logic                       regulator_enable_pin_pu
);
	localparam logic [rcec_pkg::CNT_W-1:0] DLY_C = rcec_pkg::CNT_W'(PIN_DLY);
	localparam logic [rcec_pkg::LF_DIV_W-1:0] DIV_C = rcec_pkg::LF_DIV_W'(LF_DIVIDE - 1);
	localparam logic [2:0] REL_C = 3'(rcec_pkg::REL_CYC);

	logic hi_s, lo_s, reg_s;

	rcec_sync3 #(.RST_VAL(1'b0)) u_hi (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (reset_high_pin),
		.dout (hi_s)
	);
	rcec_sync3 #(.RST_VAL(1'b1)) u_lo (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (reset_low_pin),
		.dout (lo_s)
	);
	rcec_sync3 #(.RST_VAL(1'b1)) u_reg (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  (regulator_enable_pin),
		.dout (reg_s)
	);

	typedef struct packed {
		logic [rcec_pkg::LF_DIV_W-1:0] div;
		logic                          tick;
		logic [rcec_pkg::CNT_W-1:0]    pcnt;
		logic                          pin_rst;
		logic [2:0]                    rel;
		logic                          irst;
		logic                          cold;
		logic [1:0]                    xsel;
		logic                          osc_cfg;
		logic                          osc_en;
		logic                          free_run;
		logic                          reg_lp;
		logic                          reg_on;
		logic                          run;
		logic                          keep;
	} rcec_st_t;
	rcec_st_t st_q, st_d;

	logic pin_req, any_src;
	assign pin_req = hi_s | ~lo_s;
	assign any_src = st_q.pin_rst | power_on_det | uart_break | watchdog_expire | fw_fault_reset;

	always_comb begin
		st_d = st_q;
		// slow-clock tick from core clock divider
		st_d.tick = 1'b0;
		if (st_q.div == DIV_C) begin
			st_d.div = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.div = st_q.div + 1'b1;
		end
		// short glitches vanish: count restarts whenever request drops
		if (!pin_req) begin
			st_d.pcnt = '0;
			st_d.pin_rst = 1'b0;
		end else if (st_q.tick && !st_q.pin_rst) begin
			st_d.pcnt = st_q.pcnt + 1'b1;
			if (st_q.pcnt == DLY_C - 1'b1) begin
				st_d.pin_rst = 1'b1;
			end
		end
		// hold while any source, then stretch a few cycles
		if (any_src || warm_reset_req) begin
			st_d.irst = 1'b1;
			st_d.rel = REL_C;
		end else if (st_q.rel != 3'h0) begin
			st_d.rel = st_q.rel - 1'b1;
		end else begin
			st_d.irst = 1'b0;
		end
		// cold wins over warm if both are seen
		if (any_src) begin
			st_d.cold = 1'b1;
		end else if (warm_reset_req && !st_q.irst) begin
			st_d.cold = 1'b0;
		end
		if (st_q.irst) begin
			st_d.xsel = rcec_pkg::XSEL_RST;
			st_d.osc_cfg = 1'b0;
		end else begin
			if (xtal_sel_wr) begin
				st_d.xsel = xtal_sel_cfg;
			end
			if (osc_pin_cfg_wr) begin
				st_d.osc_cfg = 1'b1;
			end
		end
		st_d.osc_en = or_func_cfg ? (host_clk_enable | own_osc_enable) : own_osc_enable;
		st_d.free_run = ~crystal_clk_present;
		st_d.reg_lp = deep_sleep;
		st_d.reg_on = reg_s;
		// complements registered so every non-constant pad control leaves a flop
		st_d.run = ~st_d.irst;
		st_d.keep = ~st_d.cold;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.irst <= 1'b1;
			st_q.cold <= 1'b1;
			st_q.xsel <= rcec_pkg::XSEL_RST;
			st_q.reg_on <= 1'b1;
			st_q.free_run <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// pad states: fixed while reset, released otherwise, except io output enables, analogue levels and three pulls that stay constant
	always_comb begin
		int_reset = st_q.irst;
		cold_reset = st_q.cold;
		retain_state = st_q.keep;
		xtal_sel = st_q.xsel;
		osc_free_run = st_q.free_run;
		osc_en_out = st_q.osc_en;
		osc_en_oe = st_q.osc_cfg;
		programmable_io_line_oe = '0;
		programmable_io_line_pd = {rcec_pkg::PIO_W{st_q.irst}};
		uart_tx_oe = st_q.run;
		uart_rts_oe = st_q.run;
		uart_pu = st_q.irst;
		spi_miso_oe = st_q.run;
		spi_miso_pd = st_q.irst;
		peripheral_chip_select_pin_pu = st_q.irst;
		reset_low_pin_pu = 1'b1;
		other_inputs_pd = st_q.irst;
		test_en_strong_pd = 1'b1;
		analogue_interface_pins_out = '0;
		analogue_interface_pins_oe = {rcec_pkg::AIO_W{st_q.irst}};
		regulator_low_power = st_q.reg_lp;
		regulator_on = st_q.reg_on;
		regulator_enable_pin_pu = 1'b1;
	end

	a_pin_delay: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		$rose(st_q.pin_rst) |-> $past(pin_req) && st_q.pcnt == DLY_C)
		else $error("pin reset taken at wrong count");
	a_hold_reset: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		any_src |=> st_q.irst)
		else $error("internal reset dropped with a source active");
	a_cold_class: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		(power_on_det || watchdog_expire || fw_fault_reset) |=> st_q.cold)
		else $error("cold reset not recorded");
	a_osc_or: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		(or_func_cfg && host_clk_enable) |=> st_q.osc_en)
		else $error("host enable not ORed onto output");
	a_osc_float: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		st_q.irst |=> !osc_en_oe)
		else $error("oscillator enable driven in reset");
	a_xtal_safe: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		st_q.irst |=> xtal_sel == rcec_pkg::XSEL_RST)
		else $error("crystal select not slowest in reset");
	a_pad_float: assert property (@(posedge clk) disable iff (!rst_n)
		int_reset |-> !uart_tx_oe && !spi_miso_oe && uart_pu)
		else $error("serial pads not floated in reset");
	a_aio_low: assert property (@(posedge clk) disable iff (!rst_n)
		int_reset |-> analogue_interface_pins_oe == {rcec_pkg::AIO_W{1'b1}} && analogue_interface_pins_out == '0)
		else $error("analogue pins not driven low");
	a_reg_lp: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		deep_sleep |=> regulator_low_power)
		else $error("regulator not in low power");
	a_release: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		$fell(st_q.irst) |-> $past(st_q.rel) == 3'h0)
		else $error("reset released early");
endmodule
`default_nettype wire

// ---- tb/rcec_host.sv ----
// host-side model: drives the reset pins, host clock enable and regulator enable
// assumes set is called at a rising clock edge; idle levels follow the pad pulls
`timescale 1ns/1ns
`default_nettype none
module rcec_host (
	output var logic reset_high_pin,
	output var logic reset_low_pin,
	output var logic host_clk_enable,
	output var logic regulator_enable_pin
);
	initial begin
		reset_high_pin = 1'b0;
		reset_low_pin = 1'b1;
		host_clk_enable = 1'b0;
		regulator_enable_pin = 1'b1;
	end
	// pin requests held well past the filter delay, or kept short as a glitch
	task automatic set(input logic hi, input logic lo_act, input logic hce, input logic ren);
		reset_high_pin <= hi;
		reset_low_pin <= ~lo_act;
		host_clk_enable <= hce;
		regulator_enable_pin <= ren;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the reset and clock-enable control block
// assumes a host model on the pins; ce is tied high
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int DLY = 4;
	localparam int DIV = 4;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [4:0] src = 5'h00;
	logic [7:0] ctl = 8'h10;
	int         failures = 0;
	int         comparisons = 0;
	wire logic  hp, lp, hce, ren;
	logic       int_reset, cold_reset, retain_state, osc_free_run, osc_en_out, osc_en_oe;
	logic       uart_tx_oe, uart_rts_oe, uart_pu, spi_miso_oe, spi_miso_pd, other_inputs_pd;
	logic       peripheral_chip_select_pin_pu, reset_low_pin_pu, test_en_strong_pd;
	logic       regulator_low_power, regulator_on, regulator_enable_pin_pu;
	logic [1:0] xtal_sel;
	logic [11:0] pio_oe, pio_pd;
	logic [2:0] an_out, an_oe;
	always #5 clk = ~clk;
	rcec_host u_rcec_host (.reset_high_pin(hp), .reset_low_pin(lp), .host_clk_enable(hce),
		.regulator_enable_pin(ren));
	rcec_top #(.PIN_DLY(DLY), .LF_DIVIDE(DIV)) u_rcec_top (.clk, .rst_n, .ce(1'b1),
		.reset_high_pin(hp), .reset_low_pin(lp), .power_on_det(src[0]), .uart_break(src[1]),
		.watchdog_expire(src[2]), .fw_fault_reset(src[3]), .warm_reset_req(src[4]),
		.crystal_clk_present(ctl[4]), .xtal_sel_cfg(ctl[7:6]), .xtal_sel_wr(ctl[3]),
		.host_clk_enable(hce), .own_osc_enable(ctl[2]), .or_func_cfg(ctl[0]), .osc_pin_cfg_wr(ctl[1]),
		.deep_sleep(ctl[5]), .regulator_enable_pin(ren), .int_reset, .cold_reset, .retain_state,
		.xtal_sel, .osc_free_run, .osc_en_out, .osc_en_oe, .programmable_io_line_oe(pio_oe),
		.programmable_io_line_pd(pio_pd), .uart_tx_oe, .uart_rts_oe, .uart_pu, .spi_miso_oe,
		.spi_miso_pd, .peripheral_chip_select_pin_pu, .reset_low_pin_pu, .other_inputs_pd,
		.test_en_strong_pd, .analogue_interface_pins_out(an_out), .analogue_interface_pins_oe(an_oe),
		.regulator_low_power, .regulator_on, .regulator_enable_pin_pu);
	task automatic results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait for the internal reset level
	task automatic wait_rst(input logic v, input int lim, output int n);
		n = 0;
		while (int_reset !== v) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				check(int_reset, v);
				results();
			end
		end
	endtask
	task automatic t_boot;
		int n;
		repeat (4) @(posedge clk);
		#1;
		check({xtal_sel, osc_en_oe, cold_reset, retain_state}, 5'h1a);
		check({pio_oe, pio_pd, an_out, an_oe}, 30'h0003ffc7);
		check({uart_tx_oe, uart_rts_oe, uart_pu, spi_miso_oe, spi_miso_pd}, 5'h05);
		check({peripheral_chip_select_pin_pu, reset_low_pin_pu, other_inputs_pd}, 3'h7);
		check({test_en_strong_pd, regulator_enable_pin_pu}, 2'h3);
		@(posedge clk);
		rst_n <= 1'b1;
		wait_rst(1'b0, 20, n);
		check({uart_tx_oe, uart_rts_oe, spi_miso_oe, uart_pu, pio_pd}, 16'he000);
		check({an_oe, other_inputs_pd, spi_miso_pd, peripheral_chip_select_pin_pu}, 6'h00);
	endtask
	// one source for four cycles; release stretch and cold flag follow
	task automatic hit(input int i, input logic cold, input logic chk);
		int n;
		@(posedge clk);
		src[i] <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(int_reset, 1'b1);
		@(posedge clk);
		src[i] <= 1'b0;
		wait_rst(1'b0, 12, n);
		check(n >= 4 && n <= 7, 1'b1);
		if (chk)
			check({cold_reset, retain_state}, {cold, ~cold});
	endtask
	// pin request held for hold cycles; long ones must hit the delay window
	task automatic t_pin(input logic lo, input int hold, input logic take);
		int n;
		int t;
		t = -1;
		@(posedge clk);
		u_rcec_host.set(~lo, lo, 1'b0, 1'b1);
		for (n = 0; n < 120; n++) begin
			@(posedge clk);
			if (n == hold)
				u_rcec_host.set(1'b0, 1'b0, 1'b0, 1'b1);
			#1;
			if (t < 0 && int_reset === 1'b1)
				t = n;
		end
		if (take)
			check(t >= (DLY - 1) * DIV && t <= (DLY + 1) * DIV + 8 && cold_reset, 1'b1);
		else
			check(t < 0, 1'b1);
		check(int_reset, 1'b0);
	endtask
	task automatic t_osc;
		@(posedge clk);
		ctl <= 8'h6b;
		u_rcec_host.set(1'b0, 1'b0, 1'b1, 1'b0);
		@(posedge clk);
		ctl <= 8'h61;
		repeat (8) @(posedge clk);
		#1;
		check({osc_en_oe, osc_en_out, xtal_sel}, 4'hd);
		check({osc_free_run, regulator_low_power, regulator_on}, 3'h6);
		@(posedge clk);
		ctl <= 8'h65;
		u_rcec_host.set(1'b0, 1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge clk);
		#1;
		check({osc_en_out, regulator_on}, 2'h3);
		@(posedge clk);
		ctl <= 8'h10;
		u_rcec_host.set(1'b0, 1'b0, 1'b1, 1'b1);
		repeat (3) @(posedge clk);
		#1;
		check({osc_en_out, osc_free_run, regulator_low_power}, 3'h0);
	endtask
	initial begin
		t_boot();
		hit(0, 1'b1, 1'b1);
		hit(1, 1'b0, 1'b0);
		hit(2, 1'b0, 1'b0);
		hit(3, 1'b1, 1'b1);
		hit(4, 1'b0, 1'b1);
		t_pin(1'b0, 60, 1'b1);
		hit(4, 1'b0, 1'b1);
		t_pin(1'b1, 60, 1'b1);
		t_pin(1'b0, 3, 1'b0);
		t_osc();
		results();
	end
endmodule
`default_nettype wire
